// >>> src/tmpt_pkg.sv
/*
 * Shared constants, mode type and cycle rounding helpers for the
 * termination power-down transition block.
 * Assumes a single 200 MHz system clock; all times are in picoseconds.
 */
package tmpt_pkg;
	localparam int CLK_PERIOD_PS = 5000;
	// Asynchronous turn-on and turn-off bounds
	localparam int ASYNC_DELAY_MIN_PS = 2000;
	localparam int ASYNC_DELAY_MAX_PS = 8500;
	// Synchronous skew bounds beyond the latency
	localparam int ON_SKEW_MIN_PS = 0;
	localparam int ON_SKEW_MAX_PS = 2500;
	localparam int OFF_SKEW_MIN_PS = 1500;
	localparam int OFF_SKEW_MAX_PS = 3500;
	// Latency offsets from the total write latency
	localparam int SYNC_LAT_OFFSET = 2;
	localparam int LEAD_OFFSET = 1;
	// Mode register zero bit 12 value that selects DLL off in power-down
	localparam logic MODE_ZERO_DLL_OFF_VALUE = 1'b0;
	localparam int LAT_W = 5;
	localparam int CNT_W = 10;

	typedef enum logic [1:0] {TMPT_SYNC, TMPT_TRANS, TMPT_ASYNC} tmpt_mode_type;

	// Least time: round up, never below one cycle
	function automatic int cyclesUp(input int ps);
		int c;
		c = (ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	// Longest time: round down, never below one cycle
	function automatic int cyclesDown(input int ps);
		int c;
		c = ps / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int ASYNC_MIN_CYC = cyclesUp(ASYNC_DELAY_MIN_PS);
	localparam int ASYNC_MAX_CYC = cyclesDown(ASYNC_DELAY_MAX_PS);
	// Skews may be zero, so no one-cycle floor here
	localparam int ON_SKEW_EARLY_CYC = (ON_SKEW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ON_SKEW_LATE_CYC = ON_SKEW_MAX_PS / CLK_PERIOD_PS;
	localparam int OFF_SKEW_EARLY_CYC = (OFF_SKEW_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int OFF_SKEW_LATE_CYC = OFF_SKEW_MAX_PS / CLK_PERIOD_PS;
endpackage

// >>> src/tmpt_term_transition.sv
/*
 * Termination timing around precharge power-down entry and exit.
 * Assumes clock-enable and termination control arrive as pins (synchronised
 * here), refresh pulses come from the command decoder on clk_sys, and the
 * latency fields are held stable by the mode register logic.
 */
`timescale 1ns/1ps
module tmpt_term_transition #(
	parameter int REFRESH_CYCLE_NS = 160,
	parameter int DLL_RELOCK_EXIT_NS = 24,
	parameter int MAX_LEAD = 32
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Pins from the controller
	input wire logic clockEnable,
	input wire logic terminationControlInput,
	// Command decode, same clock
	input wire logic refreshCmd,
	// Mode configuration
	input wire logic [tmpt_pkg::LAT_W-1:0] casWriteLatency,
	input wire logic [tmpt_pkg::LAT_W-1:0] additiveLatency,
	input wire logic modeRegZeroDllBit,
	// Termination state
	output logic terminationAny,
	output logic terminationFull,
	output logic transitionActive,
	output logic asyncMode
);
	import tmpt_pkg::*;

	localparam int REFRESH_CYC = cyclesUp(REFRESH_CYCLE_NS * 1000);
	localparam int RELOCK_CYC = cyclesUp(DLL_RELOCK_EXIT_NS * 1000);
	localparam int LEAD_W = $clog2(MAX_LEAD + 1);

	function automatic logic [CNT_W-1:0] minC(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
		return (a < b) ? a : b;
	endfunction

	function automatic logic [CNT_W-1:0] maxC(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] b);
		return (a > b) ? a : b;
	endfunction

	// Bound for one mode: a transition takes the lesser start and the greater end
	function automatic logic [CNT_W-1:0] pickBound(input tmpt_mode_type m,
		input logic [CNT_W-1:0] syncV, input logic [CNT_W-1:0] asyncV, input logic latest);
		logic [CNT_W-1:0] r;
		unique case (m)
			TMPT_SYNC: r = syncV;
			TMPT_ASYNC: r = asyncV;
			TMPT_TRANS: r = latest ? maxC(syncV, asyncV) : minC(syncV, asyncV);
			default: r = syncV;
		endcase
		return r;
	endfunction

	logic [1:0] ckeSync;
	logic [1:0] termSync;
	logic ckePrev;
	logic [MAX_LEAD:0] ckeHist;
	logic [MAX_LEAD:0] termHist;
	logic termPrev;
	logic pendLevel;
	logic [CNT_W-1:0] refreshLeft;
	logic [CNT_W-1:0] windowLeft;
	logic [CNT_W-1:0] earlyCnt;
	logic [CNT_W-1:0] lateCnt;

	wire logic [LAT_W:0] writeLatencyTotal = {1'b0, casWriteLatency} + {1'b0, additiveLatency};
	wire logic [CNT_W-1:0] writeLatCnt = CNT_W'(writeLatencyTotal);
	// Both synchronous latencies sit two clocks under the write latency
	wire logic [CNT_W-1:0] syncLatency = writeLatCnt - CNT_W'(SYNC_LAT_OFFSET);
	// Lead time: write latency less one, one past either sync latency
	wire logic [CNT_W-1:0] leadTime = writeLatCnt - CNT_W'(LEAD_OFFSET);
	// Lead beyond the history depth is clipped; keep MAX_LEAD above the largest WL
	wire logic [CNT_W-1:0] leadClip = minC(leadTime, CNT_W'(MAX_LEAD));
	wire logic [LEAD_W-1:0] leadIdx = LEAD_W'(leadClip);
	wire logic dllOffSelected = (modeRegZeroDllBit == MODE_ZERO_DLL_OFF_VALUE);

	wire logic ckeNow = ckeSync[1];
	wire logic ckeFall = ckePrev & ~ckeNow;
	wire logic ckeRise = ~ckePrev & ckeNow;

	// Entry period: lead time, or the refresh remainder if that is longer
	wire logic [CNT_W-1:0] entryLen = maxC(leadTime, refreshLeft);
	wire logic [CNT_W-1:0] exitLen = leadTime + CNT_W'(RELOCK_CYC);

	// The window is counted from the sampling edge while clock-enable is applied lead cycles late,
	// so it opens one lead time before that edge in the delayed frame.
	logic [CNT_W-1:0] next_windowLeft;
	always_comb begin
		next_windowLeft = (windowLeft != '0) ? windowLeft - 1'b1 : '0;
		if (!dllOffSelected) begin
			next_windowLeft = '0;
		end else if (ckeRise) begin
			// Exit replaces any entry remainder: ends at the exit end
			next_windowLeft = exitLen;
		end else if (ckeFall) begin
			// A still-running exit period is kept if it ends after the entry end
			next_windowLeft = maxC(next_windowLeft, entryLen);
		end
	end

	wire logic ckeDly = ckeHist[leadIdx];
	wire logic termDly = termHist[leadIdx];
	wire logic termEdge = termDly != termPrev;

	wire tmpt_mode_type mode = (windowLeft != '0) ? TMPT_TRANS :
		(dllOffSelected && !ckeDly) ? TMPT_ASYNC : TMPT_SYNC;

	wire logic [CNT_W-1:0] syncEarly = maxC(CNT_W'(1), syncLatency +
		(termDly ? CNT_W'(ON_SKEW_EARLY_CYC) : CNT_W'(OFF_SKEW_EARLY_CYC)));
	wire logic [CNT_W-1:0] syncLate = maxC(CNT_W'(1), syncLatency +
		(termDly ? CNT_W'(ON_SKEW_LATE_CYC) : CNT_W'(OFF_SKEW_LATE_CYC)));

	// Transition takes the lesser earliest and the greater latest bound
	wire logic [CNT_W-1:0] lateDelay = pickBound(mode, syncLate,
		CNT_W'(ASYNC_MAX_CYC), 1'b1);
	wire logic [CNT_W-1:0] earlyPick = pickBound(mode, syncEarly,
		CNT_W'(ASYNC_MIN_CYC), 1'b0);
	// Whole-cycle rounding can put the off start after its end; keep them in order
	wire logic [CNT_W-1:0] earlyDelay = minC(earlyPick, lateDelay);

	wire logic earlyFire = (earlyCnt == CNT_W'(1));
	wire logic lateFire = (lateCnt == CNT_W'(1));

	// First stage feeds only the second
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			// Idle level, so a release with clock-enable high shows no edge
			ckeSync <= '1;
			termSync <= '0;
		end else begin
			ckeSync <= {ckeSync[0], clockEnable};
			termSync <= {termSync[0], terminationControlInput};
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ckePrev <= 1'b1;
			ckeHist <= '1;
			termHist <= '0;
			termPrev <= 1'b0;
		end else begin
			ckePrev <= ckeNow;
			ckeHist <= {ckeHist[MAX_LEAD-1:0], ckeNow};
			termHist <= {termHist[MAX_LEAD-1:0], termSync[1]};
			termPrev <= termDly;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			refreshLeft <= '0;
			windowLeft <= '0;
		end else begin
			refreshLeft <= refreshCmd ? CNT_W'(REFRESH_CYC) :
				(refreshLeft != '0) ? refreshLeft - 1'b1 : '0;
			windowLeft <= next_windowLeft;
		end
	end

	// Rising: leaves high-Z early, fully on late; falling: starts off early, high-Z late
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			earlyCnt <= '0;
			lateCnt <= '0;
			pendLevel <= 1'b0;
		end else if (termEdge) begin
			earlyCnt <= earlyDelay;
			lateCnt <= lateDelay;
			pendLevel <= termDly;
		end else begin
			earlyCnt <= (earlyCnt != '0) ? earlyCnt - 1'b1 : '0;
			lateCnt <= (lateCnt != '0) ? lateCnt - 1'b1 : '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			terminationAny <= 1'b0;
			terminationFull <= 1'b0;
		end else begin
			if (earlyFire && pendLevel) begin
				terminationAny <= 1'b1;
			end else if (lateFire && !pendLevel) begin
				terminationAny <= 1'b0;
			end
			if (lateFire && pendLevel) begin
				terminationFull <= 1'b1;
			end else if (earlyFire && !pendLevel) begin
				terminationFull <= 1'b0;
			end
		end
	end

	// Uncertainty and async-mode flags for the controller's scheduling
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			transitionActive <= 1'b0;
			asyncMode <= 1'b0;
		end else begin
			transitionActive <= (mode == TMPT_TRANS);
			asyncMode <= (mode == TMPT_ASYNC);
		end
	end
endmodule

// >>> verification/tmpt_ctrl_model.sv
/* Controller model driving clock-enable and termination control.
   Assumes the bench calls drive from falling-edge context. */
`timescale 1ns/1ps
module tmpt_ctrl_model (
	// Clock
	input wire logic clk_sys,
	// Pins to the device
	output logic clockEnable,
	output logic terminationControlInput
);
	initial begin
		clockEnable = 1'b1;
		terminationControlInput = 1'b0;
	end
	// Pins move at the falling edge, then hold until the next call
	task automatic drive(input logic cke, input logic term);
		@(negedge clk_sys);
		clockEnable = cke;
		terminationControlInput = term;
	endtask
endmodule

// >>> verification/tmpt_chk_sva.sv
/* Checker of the termination outputs.
   Assumes write latency of at least five clocks. */
`timescale 1ns/1ps
module tmpt_chk (
	// Clock, reset, mode
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic modeRegZeroDllBit,
	// Watched outputs
	input wire logic terminationAny,
	input wire logic terminationFull,
	input wire logic transitionActive,
	input wire logic asyncMode
);
	import tmpt_pkg::*;
	logic [7:0] win;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Saturating window run length
	always_ff @(posedge clk_sys) begin
		win <= (rst || !transitionActive) ? 8'h00 : win + {7'h00, win != 8'hFF};
	end
	sequence s_on; ##[0:8] terminationFull; endsequence
	sequence s_off; ##[0:8] !terminationAny; endsequence
	a_dll_on_quiet: assert property (modeRegZeroDllBit |-> !(transitionActive || asyncMode))
		else $error("window with DLL kept on");
	a_full_needs_any: assert property (terminationFull |-> terminationAny)
		else $error("full without begun");
	a_on_bounded: assert property ($rose(terminationAny) |-> s_on)
		else $error("turn-on not completed");
	a_off_bounded: assert property ($fell(terminationFull) |-> s_off)
		else $error("turn-off not completed");
	a_async_after_entry: assert property ($rose(asyncMode) |-> $past(transitionActive))
		else $error("async without entry window");
	a_exit_in_window: assert property ($fell(asyncMode) |-> transitionActive)
		else $error("async left outside window");
	a_window_max: assert property (win < 8'h50)
		else $error("window too long");
	a_window_min: assert property ($fell(transitionActive) |-> win >= 8'h04)
		else $error("window shorter than lead");
endmodule
bind tmpt_term_transition tmpt_chk i_chk (.clk_sys(clk_sys), .rst(rst),
	.modeRegZeroDllBit(modeRegZeroDllBit), .terminationAny(terminationAny),
	.terminationFull(terminationFull), .transitionActive(transitionActive),
	.asyncMode(asyncMode));

// >>> verification/testbench.sv
/* Self-checking bench, one task per scenario.
   Assumes write latency 5, additive 0: lead 4, relock 5 cycles. */
`timescale 1ns/1ps
module testbench;
	import tmpt_pkg::*;
	logic clk_sys, rst, refreshCmd, dllBit, cke, termIn, tAny, tFull, tAct, asy;
	int error_cnt = 0;
	int comparisons = 0;
	int len, g;
	tmpt_ctrl_model i_ctl (.clk_sys(clk_sys), .clockEnable(cke), .terminationControlInput(termIn));
	tmpt_term_transition i_dut (.clk_sys(clk_sys), .rst(rst), .clockEnable(cke),
		.terminationControlInput(termIn), .refreshCmd(refreshCmd), .casWriteLatency(5'h05),
		.additiveLatency(5'h00), .modeRegZeroDllBit(dllBit), .terminationAny(tAny),
		.terminationFull(tFull), .transitionActive(tAct), .asyncMode(asy));
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task automatic do_reset(input logic b);
		rst = 1'b1;
		dllBit = b;
		tick(5);
		rst = 1'b0;
		tick(40);
	endtask
	// Window length, or gap between the two termination outputs
	task automatic meas(input bit gapMode, input logic lvl, output int n2);
		int n;
		n = 0;
		n2 = 0;
		while ((gapMode ? (tAny !== lvl && tFull !== lvl) : tAct !== 1'b1) && n < 40) begin
			tick(1);
			n++;
		end
		while ((gapMode ? (tAny !== lvl || tFull !== lvl) : tAct === 1'b1) && n2 < 120) begin
			tick(1);
			n2++;
		end
		if (n == 40 || n2 == 120) begin
			error_cnt++;
			finish_test();
		end
	endtask
	// Control pin moves one clock ahead of clock-enable, inside the lead
	task automatic t_edge(input logic ckeLvl, input logic [7:0] expLen);
		fork
			meas(0, 1'b1, len);
			meas(1, ~ckeLvl, g);
			begin
				i_ctl.drive(~ckeLvl, ~ckeLvl);
				i_ctl.drive(ckeLvl, ~ckeLvl);
			end
		join
		check(8'(len), expLen);
		check(8'(g), 8'h02);
		tick(10);
		check({7'h00, asy}, {7'h00, ~ckeLvl});
		$display("edge test done");
	endtask
	task automatic t_refresh();
		refreshCmd = 1'b1;
		tick(1);
		refreshCmd = 1'b0;
		fork
			meas(0, 1'b1, len);
			i_ctl.drive(1'b0, 1'b0);
		join
		check({7'h00, len >= 25 && len <= 32}, 8'h01);
		i_ctl.drive(1'b1, 1'b0);
		tick(40);
		$display("refresh test done");
	endtask
	// One-cycle pulse merges both periods
	task automatic t_short(input logic lvl);
		fork
			meas(0, 1'b1, len);
			begin
				i_ctl.drive(lvl, 1'b0);
				i_ctl.drive(~lvl, 1'b0);
			end
		join
		check({7'h00, len >= 9 && len <= 12}, 8'h01);
		tick(30);
		$display("short pulse test done");
	endtask
	task automatic t_dll();
		logic seen;
		seen = 1'b0;
		do_reset(1'b1);
		fork
			repeat (60) begin
				tick(1);
				seen = seen | tAct | asy;
			end
			meas(1, 1'b1, g);
			begin
				i_ctl.drive(1'b0, 1'b1);
				tick(20);
				i_ctl.drive(1'b1, 1'b0);
			end
		join
		check({7'h00, seen}, 8'h00);
		check(8'(g), 8'h00);
		$display("DLL kept on test done");
	endtask
	initial begin
		refreshCmd = 1'b0;
		do_reset(MODE_ZERO_DLL_OFF_VALUE);
		t_edge(1'b0, 8'h04);
		t_edge(1'b1, 8'h09);
		t_refresh();
		t_short(1'b0);
		i_ctl.drive(1'b0, 1'b0);
		tick(40);
		t_short(1'b1);
		t_dll();
		finish_test();
	end
endmodule
